/* File: rtl/ouvfh_cfg_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface ouvfh_cfg_if;
  logic [15:0] limit;
  logic [1:0]  response;
  logic [2:0]  retries;
  logic [2:0]  delay_code;

  modport regs (output limit, output response, output retries, output delay_code);
  modport core (input limit, input response, input retries, input delay_code);
endinterface : ouvfh_cfg_if

`default_nettype wire

/* File: rtl/ouvfh_defines.svh */
`ifndef OUVFH_DEFINES_SVH
`define OUVFH_DEFINES_SVH

// ****************************************************************
// Command codes of the two registers
// ****************************************************************
`define OUVFH_CMD_UV_LIMIT      8'h44
`define OUVFH_CMD_UV_REACT      8'h45

// ****************************************************************
// Reaction byte field layout
// ****************************************************************
`define OUVFH_RESP_HI           7
`define OUVFH_RESP_LO           6
`define OUVFH_RETRY_HI          5
`define OUVFH_RETRY_LO          3
`define OUVFH_DELAY_HI          2
`define OUVFH_DELAY_LO          0

// ****************************************************************
// Field codes
// ****************************************************************
`define OUVFH_RESP_IGNORE       2'h0
`define OUVFH_RESP_DELAY        2'h1
`define OUVFH_RESP_SHUTDOWN     2'h2
`define OUVFH_RESP_HOLD         2'h3
`define OUVFH_RETRY_NONE        3'h0
`define OUVFH_RETRY_CONT        3'h7

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define OUVFH_LIMIT_RESET       16'h0000
`define OUVFH_REACT_RESET       8'h00
`define OUVFH_BYTE_PAD          8'h00
`define OUVFH_UNITS_ONE         8'h01
`define OUVFH_UNITS_ZERO        8'h00
`define OUVFH_ATTEMPT_ZERO      3'h0
`define OUVFH_ATTEMPT_ONE       3'h1

`endif

/* File: rtl/ouvfh_pkg.sv */
package ouvfh_pkg;

  typedef enum logic [7:0] {
    OUVFH_ST_IDLE    = 8'h01,
    OUVFH_ST_RUN     = 8'h02,
    OUVFH_ST_DELAY   = 8'h04,
    OUVFH_ST_OFF     = 8'h08,
    OUVFH_ST_KICK    = 8'h10,
    OUVFH_ST_ATTEMPT = 8'h20,
    OUVFH_ST_HOLD    = 8'h40,
    OUVFH_ST_LATCHED = 8'h80
  } ouvfh_state_t;

endpackage : ouvfh_pkg

/* File: rtl/ouvfh_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ouvfh_defines.svh"

module ouvfh_regs
  import ouvfh_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output var  logic        rsp_valid,
  output var  logic [15:0] rsp_rdata,
  output var  logic        rsp_unsupported,
  ouvfh_cfg_if.regs        cfg
);

  logic [15:0] limit_reg;
  logic [7:0]  react_reg;

  wire hit_limit = cmd_code == `OUVFH_CMD_UV_LIMIT;
  wire hit_react = cmd_code == `OUVFH_CMD_UV_REACT;
  wire wr_limit  = cmd_valid & cmd_write & hit_limit;
  wire wr_react  = cmd_valid & cmd_write & hit_react;
  wire [15:0] rd_mux = hit_limit ? limit_reg :
                       hit_react ? {`OUVFH_BYTE_PAD, react_reg} : `OUVFH_LIMIT_RESET;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      limit_reg       <= `OUVFH_LIMIT_RESET;
      react_reg       <= `OUVFH_REACT_RESET;
      rsp_valid       <= 1'b0;
      rsp_rdata       <= `OUVFH_LIMIT_RESET;
      rsp_unsupported <= 1'b0;
    end else begin
      if (wr_limit) limit_reg <= cmd_wdata;
      if (wr_react) react_reg <= cmd_wdata[7:0];
      rsp_valid       <= cmd_valid;
      rsp_rdata       <= (cmd_valid & ~cmd_write) ? rd_mux : `OUVFH_LIMIT_RESET;
      rsp_unsupported <= cmd_valid & ~(hit_limit | hit_react);
    end
  end

  assign cfg.limit      = limit_reg;
  assign cfg.response   = react_reg[`OUVFH_RESP_HI:`OUVFH_RESP_LO];
  assign cfg.retries    = react_reg[`OUVFH_RETRY_HI:`OUVFH_RETRY_LO];
  assign cfg.delay_code = react_reg[`OUVFH_DELAY_HI:`OUVFH_DELAY_LO];

endmodule : ouvfh_regs

`default_nettype wire

/* File: rtl/ouvfh_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ouvfh_defines.svh"

module ouvfh_timer
  import ouvfh_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       start,
  input  wire logic [2:0] delay_code,
  input  wire logic       unit_tick,
  output var  logic       done
);

  logic [7:0] count_reg;

  // Units double per code step, so code 7 gives 128 units.
  wire [7:0] load_units = `OUVFH_UNITS_ONE << delay_code;
  wire       last_unit  = count_reg == `OUVFH_UNITS_ONE;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= `OUVFH_UNITS_ZERO;
      done      <= 1'b0;
    end else begin
      done <= ~start & unit_tick & last_unit;
      if (start) begin
        count_reg <= load_units;
      end else if (unit_tick && count_reg != `OUVFH_UNITS_ZERO) begin
        count_reg <= count_reg - `OUVFH_UNITS_ONE;
      end
    end
  end

endmodule : ouvfh_timer

`default_nettype wire

/* File: rtl/ouvfh_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ouvfh_defines.svh"

module ouvfh_top
  import ouvfh_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output var  logic        rsp_valid,
  output var  logic [15:0] rsp_rdata,
  output var  logic        rsp_unsupported,
  input  wire logic [15:0] vout_meas,
  input  wire logic        unit_tick,
  input  wire logic        output_on_cmd,
  input  wire logic        clear_faults,
  input  wire logic        status_clear,
  input  wire logic        other_fault_off,
  output var  logic        output_enable,
  output var  logic        uv_fault_status,
  output var  logic        uv_fault_active,
  output var  logic        fault_latched,
  output var  logic [2:0]  attempt_count
);

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  ouvfh_cfg_if cfg ();

  ouvfh_regs u_regs (
    .clk             (clk),
    .arst_n          (arst_n),
    .cmd_valid       (cmd_valid),
    .cmd_write       (cmd_write),
    .cmd_code        (cmd_code),
    .cmd_wdata       (cmd_wdata),
    .rsp_valid       (rsp_valid),
    .rsp_rdata       (rsp_rdata),
    .rsp_unsupported (rsp_unsupported),
    .cfg             (cfg)
  );

  // ****************************************************************
  // Delay and retry interval timer
  // ****************************************************************
  logic timer_start;
  logic timer_done;

  ouvfh_timer u_timer (
    .clk        (clk),
    .arst_n     (arst_n),
    .start      (timer_start),
    .delay_code (cfg.delay_code),
    .unit_tick  (unit_tick),
    .done       (timer_done)
  );

  // ****************************************************************
  // Fault detection and clear sources
  // ****************************************************************
  ouvfh_state_t state_reg;
  ouvfh_state_t state_next;
  logic [2:0]   attempts_reg;
  logic [2:0]   attempts_next;
  logic         on_cmd_reg;
  logic         uv_now_reg;

  wire uv_below  = vout_meas < cfg.limit;
  wire on_rise   = output_on_cmd & ~on_cmd_reg;
  wire sw_clear  = clear_faults | status_clear;
  wire any_clear = sw_clear | on_rise;

  wire resp_ignore = cfg.response == `OUVFH_RESP_IGNORE;
  wire resp_delay  = cfg.response == `OUVFH_RESP_DELAY;
  wire resp_shut   = cfg.response == `OUVFH_RESP_SHUTDOWN;
  wire resp_hold   = cfg.response == `OUVFH_RESP_HOLD;

  wire retry_none  = cfg.retries == `OUVFH_RETRY_NONE;
  wire retry_cont  = cfg.retries == `OUVFH_RETRY_CONT;
  // Counting stops at the programmed attempt number; the continuous code never ends.
  wire retry_spent = ~retry_cont & (attempts_reg >= cfg.retries);

  // The fault is acted on only while the output is being regulated.
  wire uv_event    = uv_now_reg & output_enable;

  // ****************************************************************
  // Reaction state machine
  // ****************************************************************
  always_comb begin
    state_next    = state_reg;
    attempts_next = attempts_reg;
    timer_start   = 1'b0;
    if (!output_on_cmd) begin
      // Commanding off ends any delay or retry sequence and drops the output.
      state_next    = OUVFH_ST_IDLE;
      attempts_next = `OUVFH_ATTEMPT_ZERO;
    end else if (other_fault_off) begin
      state_next = OUVFH_ST_LATCHED;
    end else begin
      case (state_reg)
        OUVFH_ST_IDLE: begin
          state_next = OUVFH_ST_RUN;
        end
        OUVFH_ST_RUN: begin
          if (uv_event) begin
            if (resp_ignore) begin
              state_next = OUVFH_ST_RUN;
            end else if (resp_delay) begin
              state_next  = OUVFH_ST_DELAY;
              timer_start = 1'b1;
            end else if (resp_shut && retry_none) begin
              state_next = OUVFH_ST_LATCHED;
            end else if (resp_shut) begin
              state_next    = OUVFH_ST_OFF;
              attempts_next = `OUVFH_ATTEMPT_ZERO;
              timer_start   = 1'b1;
            end else if (resp_hold) begin
              state_next = OUVFH_ST_HOLD;
            end else begin
              state_next = OUVFH_ST_RUN;
            end
          end
        end
        OUVFH_ST_DELAY: begin
          if (!uv_now_reg) begin
            state_next = OUVFH_ST_RUN;
          end else if (timer_done && retry_none) begin
            state_next = OUVFH_ST_LATCHED;
          end else if (timer_done) begin
            state_next    = OUVFH_ST_OFF;
            attempts_next = `OUVFH_ATTEMPT_ZERO;
            timer_start   = 1'b1;
          end
        end
        OUVFH_ST_OFF: begin
          if (timer_done) begin
            state_next    = OUVFH_ST_KICK;
            attempts_next = attempts_reg + `OUVFH_ATTEMPT_ONE;
            timer_start   = 1'b1;
          end
        end
        OUVFH_ST_KICK: begin
          state_next = OUVFH_ST_ATTEMPT;
        end
        OUVFH_ST_ATTEMPT: begin
          if (timer_done && !uv_now_reg) begin
            state_next    = OUVFH_ST_RUN;
            attempts_next = `OUVFH_ATTEMPT_ZERO;
          end else if (timer_done && retry_spent) begin
            state_next = OUVFH_ST_LATCHED;
          end else if (timer_done) begin
            // The next start falls one full interval after this one began.
            state_next    = OUVFH_ST_KICK;
            attempts_next = retry_cont ? attempts_reg : attempts_reg + `OUVFH_ATTEMPT_ONE;
            timer_start   = 1'b1;
          end
        end
        OUVFH_ST_HOLD: begin
          if (!uv_now_reg) begin
            state_next = OUVFH_ST_RUN;
          end
        end
        OUVFH_ST_LATCHED: begin
          if (any_clear) begin
            state_next    = OUVFH_ST_RUN;
            attempts_next = `OUVFH_ATTEMPT_ZERO;
          end
        end
        default: begin
          state_next    = OUVFH_ST_IDLE;
          attempts_next = `OUVFH_ATTEMPT_ZERO;
        end
      endcase
    end
  end

  // ****************************************************************
  // Output drive and status
  // ****************************************************************
  wire en_next = (state_next == OUVFH_ST_RUN) |
                 (state_next == OUVFH_ST_DELAY) |
                 (state_next == OUVFH_ST_ATTEMPT);

  // A new event in the cycle of a clear keeps the status bit set.
  wire status_next = uv_event | (uv_fault_status & ~sw_clear);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= OUVFH_ST_IDLE;
      attempts_reg <= `OUVFH_ATTEMPT_ZERO;
      // Resetting to the on level stops an on command held through reset from looking like a rise.
      on_cmd_reg   <= 1'b1;
      uv_now_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      attempts_reg <= attempts_next;
      on_cmd_reg   <= output_on_cmd;
      uv_now_reg   <= uv_below;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      output_enable   <= 1'b0;
      uv_fault_status <= 1'b0;
      uv_fault_active <= 1'b0;
      fault_latched   <= 1'b0;
      attempt_count   <= `OUVFH_ATTEMPT_ZERO;
    end else begin
      output_enable   <= en_next;
      uv_fault_status <= status_next;
      uv_fault_active <= uv_below;
      fault_latched   <= state_next == OUVFH_ST_LATCHED;
      attempt_count   <= attempts_next;
    end
  end

endmodule : ouvfh_top

`default_nettype wire

/* File: sim/ouvfh_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host side of the command port
// ****************************************************************
module ouvfh_host_model (
  input  wire logic        clk,
  output var  logic        cmd_valid,
  output var  logic        cmd_write,
  output var  logic [7:0]  cmd_code,
  output var  logic [15:0] cmd_wdata,
  input  wire logic [15:0] rsp_rdata,
  input  wire logic        rsp_unsupported
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // Released data is inverted so a stale word is never taken for a fresh one.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic u);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code  <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~d;
    @(negedge clk);
    q = rsp_rdata;
    u = rsp_unsupported;
  endtask : xfer
endmodule : ouvfh_host_model
`default_nettype wire

/* File: sim/ouvfh_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Port checker
// ****************************************************************
module ouvfh_top_assertions (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_rdata,
  input wire logic        rsp_unsupported,
  input wire logic [15:0] vout_meas,
  input wire logic        unit_tick,
  input wire logic        output_on_cmd,
  input wire logic        clear_faults,
  input wire logic        status_clear,
  input wire logic        other_fault_off,
  input wire logic        output_enable,
  input wire logic        uv_fault_status,
  input wire logic        uv_fault_active,
  input wire logic        fault_latched,
  input wire logic [2:0]  attempt_count
);
  logic [15:0] lim_reg;
  logic [7:0]  rea_reg;
  wire         is_lim = cmd_code == 8'h44;
  wire         is_rea = cmd_code == 8'h45;
  wire         unsup  = !is_lim && !is_rea;
  wire  [15:0] rd_exp = cmd_write ? 16'h0000 :
                        is_lim ? lim_reg : is_rea ? {8'h00, rea_reg} : 16'h0000;
  wire         uv_exp = vout_meas < lim_reg;
  wire  [1:0]  mode   = rea_reg[7:6];
  wire  [2:0]  tries  = rea_reg[5:3];
  wire         fresh  = output_enable && attempt_count == 3'h0 && !other_fault_off;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lim_reg <= 16'h0000;
      rea_reg <= 8'h00;
    end else if (cmd_valid && cmd_write && is_lim) begin
      lim_reg <= cmd_wdata;
    end else if (cmd_valid && cmd_write && is_rea) begin
      rea_reg <= cmd_wdata[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_RSP: assert property (cmd_valid |=> rsp_valid && rsp_unsupported == $past(unsup))
    else $error("bad response strobe");
  AST_RSP_IDLE: assert property (!cmd_valid |=> !rsp_valid && !rsp_unsupported)
    else $error("response without request");
  AST_RDATA: assert property (cmd_valid |=> rsp_rdata == $past(rd_exp))
    else $error("bad read data");
  AST_UV_CMP: assert property (uv_fault_active == $past(uv_exp))
    else $error("bad fault compare");
  AST_IGNORE: assert property (
    mode == 2'h0 && output_enable && output_on_cmd && !other_fault_off |=> output_enable)
    else $error("ignore mode dropped output");
  AST_SHUT: assert property (
    mode[1] && $rose(uv_fault_active) && fresh |=> !output_enable)
    else $error("output not disabled");
  AST_DELAY_ON: assert property (
    mode == 2'h1 && $rose(uv_fault_active) && fresh && output_on_cmd
    |=> output_enable ##1 output_enable) else $error("delay mode stopped early");
  AST_HOLD: assert property (
    mode == 2'h3 && $fell(uv_fault_active) && output_on_cmd && !fault_latched
    && !other_fault_off |-> ##[1:3] output_enable) else $error("hold did not resume");
  AST_NO_RETRY: assert property (
    mode == 2'h2 && tries == 3'h0 && $rose(uv_fault_active) && fresh
    |-> ##[1:4] fault_latched && attempt_count == 3'h0) else $error("retry with count 0");
  AST_COUNT: assert property (
    $rose(fault_latched) && !$past(other_fault_off) && tries != 3'h0 && tries != 3'h7
    |-> attempt_count == tries) else $error("bad attempt count");
  AST_CONT: assert property (
    $rose(fault_latched) && tries == 3'h7 |-> $past(other_fault_off))
    else $error("continuous retry stopped");
  AST_CLEAR: assert property (
    fault_latched && (clear_faults || status_clear) && !other_fault_off |=> !fault_latched)
    else $error("latch not cleared");
  AST_OFF: assert property (!output_on_cmd |=> !output_enable && !fault_latched)
    else $error("off command ignored");
  COV_LATCH: cover property ($rose(fault_latched));
  COV_HOLD: cover property (mode == 2'h3 && $fell(uv_fault_active));
  COV_UNSUP: cover property (rsp_unsupported);
endmodule : ouvfh_top_assertions
bind ouvfh_top ouvfh_top_assertions i_chk (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
  .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
  .rsp_rdata(rsp_rdata), .rsp_unsupported(rsp_unsupported), .vout_meas(vout_meas),
  .unit_tick(unit_tick), .output_on_cmd(output_on_cmd), .clear_faults(clear_faults),
  .status_clear(status_clear), .other_fault_off(other_fault_off), .output_enable(output_enable),
  .uv_fault_status(uv_fault_status), .uv_fault_active(uv_fault_active),
  .fault_latched(fault_latched), .attempt_count(attempt_count));
`default_nettype wire

/* File: sim/tb_ouvfh_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bench
// ****************************************************************
module tb_ouvfh_top;
  logic        clk, arst_n, cmd_valid, cmd_write, rsp_valid, rsp_unsupported, unit_tick;
  logic        output_on_cmd, clear_faults, status_clear, other_fault_off, output_enable;
  logic        uv_fault_status, uv_fault_active, fault_latched;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, rsp_rdata, vout_meas;
  logic [2:0]  attempt_count;
  logic [1:0]  tick_div;
  int          mismatches, samples_checked, t, n;
  ouvfh_top i_dut (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_unsupported(rsp_unsupported), .vout_meas(vout_meas), .unit_tick(unit_tick),
    .output_on_cmd(output_on_cmd), .clear_faults(clear_faults), .status_clear(status_clear),
    .other_fault_off(other_fault_off), .output_enable(output_enable),
    .uv_fault_status(uv_fault_status), .uv_fault_active(uv_fault_active),
    .fault_latched(fault_latched), .attempt_count(attempt_count));
  ouvfh_host_model i_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_rdata(rsp_rdata),
    .rsp_unsupported(rsp_unsupported));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // The delay unit is one tick in four cycles, so every interval is an exact tick count.
  always @(posedge clk) begin
    tick_div  <= tick_div + 2'h1;
    unit_tick <= tick_div == 2'h3;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] c, input logic [15:0] e, input logic ue);
    logic [15:0] q;
    logic        u;
    i_host.xfer(1'b0, c, 16'h0000, q, u);
    chk(q, e, "read data");
    chk({15'h0000, u}, {15'h0000, ue}, "unsupported flag");
  endtask : rd
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] q;
    logic        u;
    i_host.xfer(1'b1, c, d, q, u);
  endtask : wr
  task automatic setv(input logic [15:0] v);
    @(posedge clk);
    vout_meas <= v;
  endtask : setv
  task automatic kick(input int k);
    @(posedge clk);
    clear_faults    <= k == 0;
    status_clear    <= k == 1;
    output_on_cmd   <= k != 2;
    other_fault_off <= k == 3;
    @(posedge clk);
    clear_faults    <= 1'b0;
    status_clear    <= 1'b0;
    output_on_cmd   <= 1'b1;
    other_fault_off <= 1'b0;
  endtask : kick
  task automatic wait_for(input logic lat, input logic v);
    n = 0;
    @(negedge clk);
    while (((lat ? fault_latched : output_enable) !== v) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, n < 3000}, 16'h0001, "wait timeout");
  endtask : wait_for
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end
  initial begin
    {arst_n, unit_tick, tick_div, clear_faults, status_clear, other_fault_off} = '0;
    output_on_cmd = 1'b1;
    vout_meas     = 16'hFFFF;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h44, 16'h0000, 1'b0);
    rd(8'h45, 16'h0000, 1'b0);
    wr(8'h45, 16'h12C3);
    rd(8'h45, 16'h00C3, 1'b0);
    wr(8'h45, 16'h0000);
    wr(8'h44, 16'h8000);
    wr(8'h46, 16'hFFFF);
    rd(8'h44, 16'h8000, 1'b0);
    rd(8'h46, 16'h0000, 1'b1);
    $display("test registers done");
    setv(16'h7FFF);
    repeat (4) @(negedge clk);
    chk({14'h0000, output_enable, uv_fault_status}, 16'h0003, "ignore");
    setv(16'h8000);
    kick(1);
    repeat (3) @(negedge clk);
    chk({14'h0000, uv_fault_active, uv_fault_status}, 16'h0000, "no fault at limit");
    $display("test ignore done");
    for (int r = 0; r < 7; r++) begin
      wr(8'h45, {8'h00, 2'b10, 3'(r), 3'b000});
      setv(16'h7000);
      wait_for(1'b1, 1'b1);
      chk({13'h0000, attempt_count}, 16'(r), "attempts");
      chk({14'h0000, output_enable, uv_fault_status}, 16'h0001, "latched off");
      setv(16'hFFFF);
      kick(r % 3);
      wait_for(1'b0, 1'b1);
    end
    $display("test retry counts done");
    wr(8'h45, 16'h00BA);
    setv(16'h7000);
    wait_for(1'b0, 1'b0);
    n = 0;
    t = 0;
    while (attempt_count !== 3'h1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    // The attempt count holds at one in the continuous code, so the interval is timed
    // from one restart kick to the next, where the output drops for a single cycle.
    for (int p = 0; p < 2; p++) begin
      t = 0;
      while (output_enable !== 1'b1 && n < 500) begin
        t += unit_tick;
        @(negedge clk);
        n++;
      end
      while (output_enable === 1'b1 && n < 500) begin
        t += unit_tick;
        @(negedge clk);
        n++;
      end
    end
    chk(16'(t), 16'h0004, "retry interval");
    repeat (300) @(negedge clk);
    chk({15'h0000, fault_latched}, 16'h0000, "continuous");
    kick(3);
    wait_for(1'b1, 1'b1);
    setv(16'hFFFF);
    kick(0);
    wait_for(1'b0, 1'b1);
    $display("test continuous done");
    wr(8'h45, 16'h0041);
    setv(16'h7000);
    wait_for(1'b1, 1'b1);
    setv(16'hFFFF);
    kick(0);
    wr(8'h45, 16'h00C0);
    setv(16'h7000);
    repeat (4) @(negedge clk);
    chk({15'h0000, output_enable}, 16'h0000, "hold off");
    setv(16'hFFFF);
    wait_for(1'b0, 1'b1);
    chk({15'h0000, fault_latched}, 16'h0000, "hold no latch");
    $display("test delay and hold done");
    results();
  end
endmodule : tb_ouvfh_top
`default_nettype wire
